// [cal_value_pkg.sv]
// register map, field widths and reset values of the calibration value bank
package cal_value_pkg;

    // ********************************************************************
    // register offsets (byte addresses)
    // ********************************************************************
    localparam logic [7:0] OFS_PLUS_FIRST = 8'h48;
    localparam logic [7:0] OFS_PLUS_ZERO = 8'h4c;
    localparam logic [7:0] OFS_MINUS_DIRECT = 8'h54;
    localparam logic [7:0] OFS_MINUS_SECONDARY = 8'h58;
    localparam logic [7:0] OFS_MINUS_FOURTH = 8'h5c;
    localparam logic [7:0] OFS_MINUS_THIRD = 8'h60;
    localparam logic [7:0] OFS_MINUS_SECOND = 8'h64;
    localparam logic [7:0] OFS_MINUS_FIRST = 8'h68;
    localparam logic [7:0] OFS_MINUS_ZERO = 8'h6c;

    // ********************************************************************
    // field widths (all fields sit at bit 0)
    // ********************************************************************
    localparam int W_ZERO = 6;
    localparam int W_FIRST = 7;
    localparam int W_SECOND = 8;
    localparam int W_THIRD = 9;
    localparam int W_FOURTH = 10;
    localparam int W_SECONDARY = 6;
    localparam int W_DIRECT = 6;

    // ********************************************************************
    // reset values
    // ********************************************************************
    localparam logic [5:0] RST_PLUS_ZERO = 6'h20;
    localparam logic [6:0] RST_PLUS_FIRST = 7'h40;
    localparam logic [5:0] RST_MINUS_DIRECT = 6'h0a;
    localparam logic [5:0] RST_MINUS_SECONDARY = 6'h20;
    localparam logic [9:0] RST_MINUS_FOURTH = 10'h200;
    localparam logic [8:0] RST_MINUS_THIRD = 9'h100;
    localparam logic [7:0] RST_MINUS_SECOND = 8'h80;
    localparam logic [6:0] RST_MINUS_FIRST = 7'h40;
    localparam logic [5:0] RST_MINUS_ZERO = 6'h20;

endpackage : cal_value_pkg

// [adc_calibration_value_regs.sv]
// bank of adc calibration value registers, loaded by calibration or software
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// R1: seven minus-side fields of 6,7,8,9,10,6,6 bits are provided.
// R2: all minus-side fields load from calibration results when calibration completes.
// R3: software may overwrite fields after calibration; linearity may then suffer.
// R4: bits above each field read zero and ignore writes.
// R5: plus first field in bits 6..0, plus zero field in bits 5..0.
// R6: plus-side fields likewise load when self-calibration completes.
// R7: a software write is stored and read back until next calibration or reset.
module adc_calibration_value_regs (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    input wire logic calDone,
    input wire logic [5:0] calPlusZero,
    input wire logic [6:0] calPlusFirst,
    input wire logic [5:0] calMinusZero,
    input wire logic [6:0] calMinusFirst,
    input wire logic [7:0] calMinusSecond,
    input wire logic [8:0] calMinusThird,
    input wire logic [9:0] calMinusFourth,
    input wire logic [5:0] calMinusSecondary,
    input wire logic [5:0] calMinusDirect,
    output logic [5:0] plusZeroField,
    output logic [6:0] plusFirstField,
    output logic [5:0] minusZeroField,
    output logic [6:0] minusFirstField,
    output logic [7:0] minusSecondField,
    output logic [8:0] minusThirdField,
    output logic [9:0] minusFourthField,
    output logic [5:0] minusSecondaryField,
    output logic [5:0] minusDirectField
);

    // ********************************************************************
    // address decode
    // ********************************************************************
    wire logic selPlusZero = regAddr == cal_value_pkg::OFS_PLUS_ZERO;
    wire logic selPlusFirst = regAddr == cal_value_pkg::OFS_PLUS_FIRST;
    wire logic selMinusZero = regAddr == cal_value_pkg::OFS_MINUS_ZERO;
    wire logic selMinusFirst = regAddr == cal_value_pkg::OFS_MINUS_FIRST;
    wire logic selMinusSecond = regAddr == cal_value_pkg::OFS_MINUS_SECOND;
    wire logic selMinusThird = regAddr == cal_value_pkg::OFS_MINUS_THIRD;
    wire logic selMinusFourth = regAddr == cal_value_pkg::OFS_MINUS_FOURTH;
    wire logic selMinusSecondary = regAddr == cal_value_pkg::OFS_MINUS_SECONDARY;
    wire logic selMinusDirect = regAddr == cal_value_pkg::OFS_MINUS_DIRECT;

    // ********************************************************************
    // write enables
    // ********************************************************************
    // exact decode: no register shows up again at an alias address
    wire logic wrPlusZero = regWrEn && selPlusZero;
    wire logic wrPlusFirst = regWrEn && selPlusFirst;
    wire logic wrMinusZero = regWrEn && selMinusZero;
    wire logic wrMinusFirst = regWrEn && selMinusFirst;
    wire logic wrMinusSecond = regWrEn && selMinusSecond;
    wire logic wrMinusThird = regWrEn && selMinusThird;
    wire logic wrMinusFourth = regWrEn && selMinusFourth;
    wire logic wrMinusSecondary = regWrEn && selMinusSecondary;
    wire logic wrMinusDirect = regWrEn && selMinusDirect;

    logic [5:0] plusZero_q;
    logic [6:0] plusFirst_q;
    logic [5:0] minusZero_q;
    logic [6:0] minusFirst_q;
    logic [7:0] minusSecond_q;
    logic [8:0] minusThird_q;
    logic [9:0] minusFourth_q;
    logic [5:0] minusSecondary_q;
    logic [5:0] minusDirect_q;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic [5:0] plusZero_d;
    logic [6:0] plusFirst_d;
    logic [5:0] minusZero_d;
    logic [6:0] minusFirst_d;
    logic [7:0] minusSecond_d;
    logic [8:0] minusThird_d;
    logic [9:0] minusFourth_d;
    logic [5:0] minusSecondary_d;
    logic [5:0] minusDirect_d;

    // ********************************************************************
    // next values
    // ********************************************************************
    // calibration completion outranks a write in the same cycle, so the
    // generated set is never half overwritten
    // R4: only field bits taken from write data

    // R6: plus-side load on completion
    assign plusZero_d =
        calDone ? calPlusZero :
        wrPlusZero ? regWrData[5:0] :
        plusZero_q;

    // R5: plus first field in bits 6..0
    assign plusFirst_d =
        calDone ? calPlusFirst :
        wrPlusFirst ? regWrData[6:0] :
        plusFirst_q;

    // R2: minus-side load on completion
    assign minusZero_d =
        calDone ? calMinusZero :
        wrMinusZero ? regWrData[5:0] :
        minusZero_q;

    // R7: writes stored otherwise
    assign minusFirst_d =
        calDone ? calMinusFirst :
        wrMinusFirst ? regWrData[6:0] :
        minusFirst_q;

    // R1: minus second field width
    assign minusSecond_d =
        calDone ? calMinusSecond :
        wrMinusSecond ? regWrData[7:0] :
        minusSecond_q;

    // R1: minus third field width
    assign minusThird_d =
        calDone ? calMinusThird :
        wrMinusThird ? regWrData[8:0] :
        minusThird_q;

    // R1: minus fourth field width
    assign minusFourth_d =
        calDone ? calMinusFourth :
        wrMinusFourth ? regWrData[9:0] :
        minusFourth_q;

    // R1: minus secondary field width
    assign minusSecondary_d =
        calDone ? calMinusSecondary :
        wrMinusSecondary ? regWrData[5:0] :
        minusSecondary_q;

    // R1: minus direct field width
    assign minusDirect_d =
        calDone ? calMinusDirect :
        wrMinusDirect ? regWrData[5:0] :
        minusDirect_q;

    // ********************************************************************
    // read mux
    // ********************************************************************
    // R4: upper bits padded with zero
    wire logic [31:0] plusZeroWord = {26'h000_0000, plusZero_q};
    wire logic [31:0] plusFirstWord = {25'h000_0000, plusFirst_q};
    wire logic [31:0] minusZeroWord = {26'h000_0000, minusZero_q};
    wire logic [31:0] minusFirstWord = {25'h000_0000, minusFirst_q};
    wire logic [31:0] minusSecondWord = {24'h00_0000, minusSecond_q};
    wire logic [31:0] minusThirdWord = {23'h00_0000, minusThird_q};
    wire logic [31:0] minusFourthWord = {22'h00_0000, minusFourth_q};
    wire logic [31:0] minusSecondaryWord = {26'h000_0000, minusSecondary_q};
    wire logic [31:0] minusDirectWord = {26'h000_0000, minusDirect_q};

    // R4: unmapped reads give zero
    wire logic [31:0] rdMux =
        selPlusZero ? plusZeroWord :
        selPlusFirst ? plusFirstWord :
        selMinusZero ? minusZeroWord :
        selMinusFirst ? minusFirstWord :
        selMinusSecond ? minusSecondWord :
        selMinusThird ? minusThirdWord :
        selMinusFourth ? minusFourthWord :
        selMinusSecondary ? minusSecondaryWord :
        selMinusDirect ? minusDirectWord : 32'h0000_0000;

    // read data stands only in the cycle after the strobe
    assign rdData_d = regRdEn ? rdMux : 32'h0000_0000;

    // ********************************************************************
    // storage
    // ********************************************************************

    // ********************************************************************
    // plus-side storage
    // ********************************************************************

    // R7: plus zero held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            plusZero_q <= cal_value_pkg::RST_PLUS_ZERO;
        end else begin
            plusZero_q <= plusZero_d;
        end
    end

    // R7: plus first held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            plusFirst_q <= cal_value_pkg::RST_PLUS_FIRST;
        end else begin
            plusFirst_q <= plusFirst_d;
        end
    end

    // ********************************************************************
    // minus-side storage
    // ********************************************************************

    // R7: minus zero held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            minusZero_q <= cal_value_pkg::RST_MINUS_ZERO;
        end else begin
            minusZero_q <= minusZero_d;
        end
    end

    // R7: minus first held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            minusFirst_q <= cal_value_pkg::RST_MINUS_FIRST;
        end else begin
            minusFirst_q <= minusFirst_d;
        end
    end

    // R7: minus second held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            minusSecond_q <= cal_value_pkg::RST_MINUS_SECOND;
        end else begin
            minusSecond_q <= minusSecond_d;
        end
    end

    // R7: minus third held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            minusThird_q <= cal_value_pkg::RST_MINUS_THIRD;
        end else begin
            minusThird_q <= minusThird_d;
        end
    end

    // R7: minus fourth held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            minusFourth_q <= cal_value_pkg::RST_MINUS_FOURTH;
        end else begin
            minusFourth_q <= minusFourth_d;
        end
    end

    // R7: minus secondary held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            minusSecondary_q <= cal_value_pkg::RST_MINUS_SECONDARY;
        end else begin
            minusSecondary_q <= minusSecondary_d;
        end
    end

    // R7: minus direct held between loads
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            minusDirect_q <= cal_value_pkg::RST_MINUS_DIRECT;
        end else begin
            minusDirect_q <= minusDirect_d;
        end
    end

    // ********************************************************************
    // read data register
    // ********************************************************************

    // cleared when idle, so a stale word never lingers on the bus
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= 32'h0000_0000;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    // field outputs follow the registers with no extra stage
    assign regRdData = rdData_q;
    assign plusZeroField = plusZero_q;
    assign plusFirstField = plusFirst_q;
    assign minusZeroField = minusZero_q;
    assign minusFirstField = minusFirst_q;
    assign minusSecondField = minusSecond_q;
    assign minusThirdField = minusThird_q;
    assign minusFourthField = minusFourth_q;
    assign minusSecondaryField = minusSecondary_q;
    assign minusDirectField = minusDirect_q;

endmodule : adc_calibration_value_regs

`default_nettype wire

// [cal_value_checker.sv]
// assertions on the calibration value bank ports
`timescale 1ns/10ps
`default_nettype none
module cal_value_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [31:0] regRdData,
    input wire logic calDone,
    input wire logic [6:0] calPlusFirst,
    input wire logic [9:0] calMinusFourth,
    input wire logic [6:0] plusFirstField,
    input wire logic [9:0] minusFourthField
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_idle_zero: assert property (!regRdEn |=> regRdData == 32'h0)
        else $error("read data not zero");
    a_unmapped_zero: assert property (regRdEn && regAddr == 8'h50 |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    a_fourth_read: assert property (regRdEn && regAddr == 8'h5c |=>
        regRdData == {22'h0, $past(minusFourthField)}) else $error("fourth field read");
    a_first_read: assert property (regRdEn && regAddr == 8'h48 |=>
        regRdData == {25'h0, $past(plusFirstField)}) else $error("plus first read");
    a_cal_load: assert property (calDone |=> minusFourthField == $past(calMinusFourth)
        && plusFirstField == $past(calPlusFirst)) else $error("calibration not loaded");
    a_fourth_hold: assert property (!calDone && !(regWrEn && regAddr == 8'h5c) |=>
        $stable(minusFourthField)) else $error("fourth field changed");
endmodule : cal_value_checker
`default_nettype wire

// [testbench.sv]
// self-checking testbench of the calibration value bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [7:0] ADR [10] = '{8'h48, 8'h4c, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64,
        8'h68, 8'h6c, 8'h50};
    localparam int W [10] = '{7, 6, 6, 6, 10, 9, 8, 7, 6, 0};
    localparam logic [31:0] RST [10] = '{cal_value_pkg::RST_PLUS_FIRST,
        cal_value_pkg::RST_PLUS_ZERO, cal_value_pkg::RST_MINUS_DIRECT,
        cal_value_pkg::RST_MINUS_SECONDARY, cal_value_pkg::RST_MINUS_FOURTH,
        cal_value_pkg::RST_MINUS_THIRD, cal_value_pkg::RST_MINUS_SECOND,
        cal_value_pkg::RST_MINUS_FIRST, cal_value_pkg::RST_MINUS_ZERO, 32'h0};
    logic sys_clk = 1'h0, nrst = 1'h0, regWrEn = 1'h0, regRdEn = 1'h0, calDone = 1'h0;
    logic [7:0] regAddr = 8'h0, calMinusSecond = 8'h0;
    logic [31:0] regWrData = 32'h0, regRdData;
    logic [5:0] calPlusZero = 6'h0, calMinusZero = 6'h0;
    logic [5:0] calMinusSecondary = 6'h0, calMinusDirect = 6'h0;
    logic [6:0] calPlusFirst = 7'h0, calMinusFirst = 7'h0;
    logic [8:0] calMinusThird = 9'h0;
    logic [9:0] calMinusFourth = 10'h0;
    logic [5:0] plusZeroField, minusZeroField, minusSecondaryField, minusDirectField;
    logic [6:0] plusFirstField, minusFirstField;
    logic [7:0] minusSecondField;
    logic [8:0] minusThirdField;
    logic [9:0] minusFourthField;
    logic [31:0] model [10] = RST;
    int nErrors = 0, testsRun = 0;
    adc_calibration_value_regs u_adc_calibration_value_regs (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .calDone(calDone),
        .calPlusZero(calPlusZero),
        .calPlusFirst(calPlusFirst),
        .calMinusZero(calMinusZero),
        .calMinusFirst(calMinusFirst),
        .calMinusSecond(calMinusSecond),
        .calMinusThird(calMinusThird),
        .calMinusFourth(calMinusFourth),
        .calMinusSecondary(calMinusSecondary),
        .calMinusDirect(calMinusDirect),
        .plusZeroField(plusZeroField),
        .plusFirstField(plusFirstField),
        .minusZeroField(minusZeroField),
        .minusFirstField(minusFirstField),
        .minusSecondField(minusSecondField),
        .minusThirdField(minusThirdField),
        .minusFourthField(minusFourthField),
        .minusSecondaryField(minusSecondaryField),
        .minusDirectField(minusDirectField)
    );
    initial forever #12.5 sys_clk = ~sys_clk;
    // far beyond the few hundred cycles the tests need
    initial #100_000 stopTest(1);
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        nErrors += int'(got !== exp);
        if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    endtask : chk
    // field output seen for table entry i, zero extended
    function automatic logic [31:0] fieldOf(input int i);
        case (i)
            0: fieldOf = 32'(plusFirstField);
            1: fieldOf = 32'(plusZeroField);
            2: fieldOf = 32'(minusDirectField);
            3: fieldOf = 32'(minusSecondaryField);
            4: fieldOf = 32'(minusFourthField);
            5: fieldOf = 32'(minusThirdField);
            6: fieldOf = 32'(minusSecondField);
            7: fieldOf = 32'(minusFirstField);
            8: fieldOf = 32'(minusZeroField);
            default: fieldOf = 32'h0000_0000;
        endcase
    endfunction : fieldOf
    // one access per call; cal inputs wander so a stray load would show
    task automatic acc(input int i, input logic we, input logic cl, input logic [31:0] d);
        @(posedge sys_clk);
        {regAddr, regWrData, regWrEn, regRdEn, calDone} <= {ADR[i], d, we, !we, cl};
        {calPlusZero, calPlusFirst, calMinusZero, calMinusFirst, calMinusSecond, calMinusThird,
            calMinusFourth, calMinusSecondary, calMinusDirect} <= 65'({$urandom, $urandom});
        @(posedge sys_clk);
        {regWrEn, regRdEn, calDone} <= 3'h0;
        if (cl) model = '{calPlusFirst, calPlusZero, calMinusDirect, calMinusSecondary,
            calMinusFourth, calMinusThird, calMinusSecond, calMinusFirst, calMinusZero, 32'h0};
        else if (we) model[i] = d & ((32'h1 << W[i]) - 32'h1);
        #1;
        if (!we && !cl) chk($sformatf("register %h", ADR[i]), regRdData, model[i]);
        chk($sformatf("field %h", ADR[i]), fieldOf(i), model[i]);
    endtask : acc
    task automatic stopTest(input int extra);
        nErrors += extra;
        $display("comparisons %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stopTest
    initial begin
        void'($urandom(77));
        repeat (16) @(posedge sys_clk);
        nrst <= 1'h1;
        for (int i = 0; i < 10; i++) acc(i, 1'h0, 1'h0, 32'h0);
        for (int n = 0; n < 60; n++) acc($urandom_range(9), n[0], 1'h0, $urandom);
        $display("reset and traffic test done");
        // later writes coincide with a load, which must win
        for (int i = 0; i < 40; i++) acc(i / 2 % 10, !i[0], i > 19, 32'hffff_ffff);
        $display("mask and calibration test done");
        // second reset in mid-run brings every register back
        nrst <= 1'h0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        model = RST;
        for (int i = 0; i < 10; i++) acc(i, 1'h0, 1'h0, 32'h0);
        $display("second reset test done");
        stopTest(0);
    end
endmodule : testbench
bind adc_calibration_value_regs cal_value_checker u_cal_value_checker (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .calDone(calDone),
    .calPlusFirst(calPlusFirst),
    .calMinusFourth(calMinusFourth),
    .plusFirstField(plusFirstField),
    .minusFourthField(minusFourthField)
);
`default_nettype wire
